// ---- rtl/idi_params.svh ----
`ifndef IDI_PARAMS_SVH
`define IDI_PARAMS_SVH

// ****************************************************************
// Interface message codes, seven bits, taken under attention
// ****************************************************************
`define IDI_CMD_GTL   7'h01
`define IDI_CMD_SDC   7'h04
`define IDI_CMD_GET   7'h08
`define IDI_CMD_LLO   7'h11
`define IDI_CMD_DCL   7'h14
`define IDI_CMD_SPE   7'h18
`define IDI_CMD_SPD   7'h19
`define IDI_CMD_UNL   7'h3f
`define IDI_CMD_UNT   7'h5f

// ****************************************************************
// Address groups and field positions
// ****************************************************************
`define IDI_LAG_BASE  7'h20
`define IDI_TAG_BASE  7'h40
`define IDI_GRP_MASK  7'h60
`define IDI_ADDR_MASK 7'h1f
`define IDI_RQS_BIT   6
`define IDI_BUS_LINES 15

`endif

// ---- rtl/idi_pkg.sv ----
`default_nettype none

package idi_pkg;

  // ****************************************************************
  // Acceptor and source handshake states
  // ****************************************************************
  typedef enum logic {
    AH_IDLE = 1'b0,  // Ready for a byte
    AH_HOLD = 1'b1   // Byte captured, waiting for valid to drop
  } idi_ah_t;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,  // Nothing to send
    SH_LOAD = 2'b01,  // Byte on the lines, waiting for ready
    SH_DAV  = 2'b10   // Valid asserted, waiting for accepted
  } idi_sh_t;

  // ****************************************************************
  // Whole state of the device interface
  // ****************************************************************
  typedef struct packed {
    idi_ah_t    ah;
    idi_sh_t    sh;
    logic       listen;
    logic       talk;
    logic       spe;
    logic       remote;
    logic       llo;
    logic       srq_pend;
    logic       stb_tx;
    logic       stb_done;
    logic [7:0] tx_lvl;
    logic       tx_eoi;
    logic       tx_ready;
    logic [7:0] rx_data;
    logic       rx_eoi;
    logic       rx_valid;
    logic       dev_clear;
    logic       trigger;
    logic       dio_oe;
    logic       dav_oe;
    logic       eoi_oe;
    logic       nrfd_oe;
    logic       ndac_oe;
  } idi_state_t;

endpackage

`default_nettype wire

// ---- rtl/idi_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for the bus lines
// ****************************************************************
module idi_sync #(
  parameter int WIDTH = 15
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] lines_i,
  output logic      [WIDTH-1:0] lines_o
);

  logic [WIDTH-1:0] meta;  // First stage, read only by the second

  // Lines idle high, so reset to released to avoid a false event
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta    <= '1;
      lines_o <= '1;
    end else begin
      meta    <= lines_i;
      lines_o <= meta;
    end
  end

endmodule // idi_sync

`default_nettype wire

// ---- rtl/idi_device.sv ----
// Operation
// RQ1: Controller sends unlisten, listen address, command.
// RQ2: Addressed commands need prior own listen address.
// RQ3: Bytes under attention decode as interface messages.
// RQ4: Command strings arrive as data after attention.
// RQ5: Send data only when addressed to talk. The code also sends when talk_only_i is set.
// RQ6: Accept data only when addressed to listen.
// RQ7: Own listen address ends talker state.
// RQ8: Own talk address ends listener state.
// RQ9: Assert valid after ready; hold until accepted.
// RQ10: Latch each byte once, then release accepted.
// RQ11: Hold service request until serviced.
// RQ12: Remote under enable, local on command, lockout.
// RQ13: Clear pulse on device or selective clear.
// RQ14: Trigger pulse on group execute trigger.
// RQ15: No parallel poll reply on data lines.
// RQ16: Never drive attention, clear or remote lines.
// RQ17: Secondary bytes leave addressing unchanged.
// RQ18: Listen address is address OR 20 hex.
// RQ19: Talk address is address OR 40 hex.
// RQ20: Decode the universal and addressed command set.
// RQ21: Interface clear idles talker and listener.
// RQ22: Serial poll sends status byte, clears request.
// RQ23: End flag marks the last byte.
`timescale 1ns/1ps
`default_nettype none
`include "idi_params.svh"

module idi_device (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Bus lines, low true
  input  wire logic [7:0] dio_n_i,
  output logic      [7:0] dio_n_o,
  output logic            dio_oe_o,
  input  wire logic       dav_n_i,
  output logic            dav_n_o,
  output logic            dav_oe_o,
  input  wire logic       nrfd_n_i,
  output logic            nrfd_n_o,
  output logic            nrfd_oe_o,
  input  wire logic       ndac_n_i,
  output logic            ndac_n_o,
  output logic            ndac_oe_o,
  input  wire logic       eoi_n_i,
  output logic            eoi_n_o,
  output logic            eoi_oe_o,
  input  wire logic       srq_n_i,
  output logic            srq_n_o,
  output logic            srq_oe_o,
  input  wire logic       atn_n_i,
  input  wire logic       ifc_n_i,
  input  wire logic       ren_n_i,
  // Instrument side
  input  wire logic [4:0] my_addr_i,
  input  wire logic       talk_only_i,
  input  wire logic       local_key_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_eoi_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_eoi_o,
  output logic            rx_valid_o,
  input  wire logic [7:0] status_i,
  input  wire logic       rqs_i,
  output logic            dev_clear_o,
  output logic            trigger_o,
  output logic            remote_o,
  output logic            lockout_o,
  output logic            listen_o,
  output logic            talk_o,
  output logic            spoll_o
);

  // ****************************************************************
  // Synchronised bus lines, turned to high-true
  // ****************************************************************
  logic [`IDI_BUS_LINES-1:0] bus_sync;  // Raw lines after two stages
  logic [7:0]                dio_t;     // Data byte, high true
  logic                      dav_t;     // Data valid asserted
  logic                      nrfd_t;    // Some acceptor not ready
  logic                      ndac_t;    // Some acceptor has not accepted
  logic                      atn_t;     // Attention asserted
  logic                      eoi_t;     // End asserted
  logic                      ifc_t;     // Interface clear asserted
  logic                      ren_t;     // Remote enable asserted

  idi_sync #(
    .WIDTH (`IDI_BUS_LINES)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .lines_i   ({dio_n_i, dav_n_i, nrfd_n_i, ndac_n_i, atn_n_i,
                 eoi_n_i, ifc_n_i, ren_n_i}),
    .lines_o   (bus_sync)
  );

  assign {dio_t, dav_t, nrfd_t, ndac_t, atn_t, eoi_t, ifc_t, ren_t} = ~bus_sync;

  // ****************************************************************
  // Address match helper
  // ****************************************************************
  function automatic logic addr_hit(input logic [6:0] cmd, input logic [6:0] base,
                                    input logic [4:0] addr);
    addr_hit = (cmd == (base | {2'b00, addr}));  // RQ18 RQ19
  endfunction

  // ****************************************************************
  // State and next state
  // ****************************************************************
  idi_pkg::idi_state_t st;       // Registered state
  idi_pkg::idi_state_t next_st;  // Combinational copy
  logic                active;   // Acceptor takes part in handshakes
  logic                cap;      // Byte captured this cycle
  logic                cap_cmd;  // Captured byte is a message
  logic [6:0]          cmd;      // Message code, parity bit dropped
  logic                src_en;   // Source may drive the lines

  assign active  = atn_t || st.listen;  // RQ3 RQ6
  assign cap     = (st.ah == idi_pkg::AH_IDLE) && active && dav_t;  // RQ10
  assign cap_cmd = cap && atn_t;  // RQ3
  assign cmd     = dio_t[6:0];
  assign src_en  = (st.talk || talk_only_i) && !atn_t;  // RQ5 RQ15

  // Next state; later assignments take priority
  always_comb begin
    next_st           = st;
    next_st.rx_valid  = 1'b0;
    next_st.dev_clear = 1'b0;
    next_st.trigger   = 1'b0;
    // Acceptor handshake
    unique case (st.ah)
      idi_pkg::AH_IDLE: begin
        if (cap) begin
          next_st.ah = idi_pkg::AH_HOLD;  // RQ10
        end
      end
      idi_pkg::AH_HOLD: begin
        if (!dav_t) begin
          next_st.ah = idi_pkg::AH_IDLE;
        end
      end
    endcase
    // Device data to the instrument
    if (cap && !atn_t && st.listen) begin
      next_st.rx_data  = dio_t;  // RQ6 RQ4
      next_st.rx_eoi   = eoi_t;  // RQ23
      next_st.rx_valid = 1'b1;
    end
    // Interface messages
    if (cap_cmd) begin
      if ((cmd & `IDI_GRP_MASK) == `IDI_GRP_MASK) begin
        next_st.listen = st.listen;  // RQ17
      end else if (cmd == `IDI_CMD_UNL) begin
        next_st.listen = 1'b0;  // RQ20
      end else if (cmd == `IDI_CMD_UNT) begin
        next_st.talk = 1'b0;  // RQ20
      end else if (addr_hit(cmd, `IDI_LAG_BASE, my_addr_i)) begin
        next_st.listen = 1'b1;  // RQ18
        next_st.talk   = 1'b0;  // RQ7
        if (ren_t) begin
          next_st.remote = 1'b1;  // RQ12
        end
      end else if (addr_hit(cmd, `IDI_TAG_BASE, my_addr_i)) begin
        next_st.talk   = 1'b1;  // RQ19
        next_st.listen = 1'b0;  // RQ8
      end else if ((cmd & `IDI_GRP_MASK) == `IDI_TAG_BASE) begin
        next_st.talk = 1'b0;  // Another talker was addressed
      end else begin
        unique case (cmd)
          `IDI_CMD_GTL: next_st.remote    = st.listen ? 1'b0 : st.remote;  // RQ2 RQ12
          `IDI_CMD_SDC: next_st.dev_clear = st.listen;  // RQ2 RQ13
          `IDI_CMD_GET: next_st.trigger   = st.listen;  // RQ2 RQ14
          `IDI_CMD_LLO: next_st.llo       = 1'b1;  // RQ12
          `IDI_CMD_DCL: next_st.dev_clear = 1'b1;  // RQ13
          `IDI_CMD_SPE: next_st.spe       = 1'b1;  // RQ20
          `IDI_CMD_SPD: next_st.spe       = 1'b0;  // RQ20
          default:      next_st.spe       = st.spe;  // Unknown codes ignored
        endcase
      end
    end
    // Remote and local
    if (!ren_t) begin
      next_st.remote = 1'b0;  // RQ12
      next_st.llo    = 1'b0;
    end else if (local_key_i && !st.llo) begin
      next_st.remote = 1'b0;  // Front key works unless locked out
    end
    // Source handshake
    next_st.tx_ready = 1'b0;
    unique case (st.sh)
      idi_pkg::SH_IDLE: begin
        if (src_en && st.spe && st.talk && !st.stb_done) begin
          next_st.tx_lvl = ~{status_i[7], st.srq_pend, status_i[5:0]};  // RQ22
          next_st.tx_eoi = 1'b0;
          next_st.stb_tx = 1'b1;
          next_st.sh     = idi_pkg::SH_LOAD;
        end else if (src_en && !st.spe && st.tx_ready && tx_valid_i) begin
          next_st.tx_lvl = ~tx_data_i;  // RQ5
          next_st.tx_eoi = tx_eoi_i;    // RQ23
          next_st.stb_tx = 1'b0;
          next_st.sh     = idi_pkg::SH_LOAD;
        end else begin
          next_st.tx_ready = src_en && !st.spe;
        end
      end
      idi_pkg::SH_LOAD: begin
        if (atn_t) begin
          next_st.sh = idi_pkg::SH_IDLE;  // Controller took the bus
        end else if (!nrfd_t && ndac_t) begin
          next_st.sh = idi_pkg::SH_DAV;  // RQ9
        end
      end
      idi_pkg::SH_DAV: begin
        if (atn_t) begin
          next_st.sh = idi_pkg::SH_IDLE;
        end else if (!ndac_t) begin
          next_st.sh = idi_pkg::SH_IDLE;  // RQ9
          if (st.stb_tx) begin
            next_st.srq_pend = 1'b0;  // RQ22
            next_st.stb_done = 1'b1;
          end
        end
      end
      default: next_st.sh = idi_pkg::SH_IDLE;  // Illegal code recovers
    endcase
    // A fresh poll needs talk or serial poll enable to drop and return first
    if (!st.talk || !st.spe) begin
      next_st.stb_done = 1'b0;
    end
    // Request set wins over the clear from a poll
    if (rqs_i) begin
      next_st.srq_pend = 1'b1;  // RQ11
    end
    // Interface clear overrides addressing
    if (ifc_t) begin
      next_st.listen = 1'b0;  // RQ21
      next_st.talk   = 1'b0;
      next_st.spe    = 1'b0;
      next_st.sh     = idi_pkg::SH_IDLE;
    end
    // Line drives follow the next state so they leave flip-flops
    next_st.dio_oe  = next_st.sh != idi_pkg::SH_IDLE;  // RQ15
    next_st.dav_oe  = next_st.sh == idi_pkg::SH_DAV;   // RQ9
    next_st.eoi_oe  = next_st.dio_oe && next_st.tx_eoi;  // RQ23
    next_st.nrfd_oe = next_st.ah == idi_pkg::AH_HOLD;  // RQ10
    next_st.ndac_oe = (next_st.ah == idi_pkg::AH_IDLE) && active;  // RQ10
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs; open-drain control lines only ever pull low, data lines drive the byte
  // ****************************************************************
  // Attention, clear and remote enable are inputs only: RQ16
  assign dio_n_o     = st.tx_lvl;
  assign dio_oe_o    = st.dio_oe;
  assign dav_n_o     = 1'b0;
  assign dav_oe_o    = st.dav_oe;
  assign nrfd_n_o    = 1'b0;
  assign nrfd_oe_o   = st.nrfd_oe;
  assign ndac_n_o    = 1'b0;
  assign ndac_oe_o   = st.ndac_oe;
  assign eoi_n_o     = 1'b0;
  assign eoi_oe_o    = st.eoi_oe;
  assign srq_n_o     = 1'b0;
  assign srq_oe_o    = st.srq_pend;  // RQ11
  assign tx_ready_o  = st.tx_ready;
  assign rx_data_o   = st.rx_data;
  assign rx_eoi_o    = st.rx_eoi;
  assign rx_valid_o  = st.rx_valid;
  assign dev_clear_o = st.dev_clear;
  assign trigger_o   = st.trigger;
  assign remote_o    = st.remote;
  assign lockout_o   = st.llo;
  assign listen_o    = st.listen;
  assign talk_o      = st.talk;
  assign spoll_o     = st.spe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_src_ready;
    st.sh == idi_pkg::SH_LOAD && !nrfd_t && ndac_t && !atn_t && !ifc_t;
  endsequence

  src_launch_a: assert property (s_src_ready |=> dav_oe_o && dio_oe_o) // RQ9
    else $error("valid not raised after ready");
  dav_ready_a: assert property ($rose(dav_oe_o) |-> $past(!nrfd_t)) // RQ9
    else $error("valid raised while not ready");
  no_ppoll_a: assert property (dio_oe_o |-> $past(!atn_t)) // RQ15
    else $error("data lines driven under attention");
  talk_gate_a: assert property ($rose(dio_oe_o) |-> $past(st.talk || talk_only_i)) // RQ5
    else $error("data sent while not talker");
  rx_once_a: assert property (rx_valid_o |-> $past(dav_t && st.listen) ##1 !rx_valid_o) // RQ10
    else $error("byte accepted wrongly or twice");
  role_excl_a: assert property (!(listen_o && talk_o)) // RQ7
    else $error("listener and talker together");
  ifc_idle_a: assert property (ifc_t |=> !listen_o && !talk_o) // RQ21
    else $error("interface clear left an address");
  get_cause_a: assert property (trigger_o |-> $past(cap_cmd && cmd == `IDI_CMD_GET && st.listen)) // RQ14
    else $error("trigger without addressed trigger");
  srq_hold_a: assert property (srq_oe_o && !(st.sh == idi_pkg::SH_DAV && st.stb_tx) |=> srq_oe_o) // RQ11
    else $error("service request dropped early");

endmodule // idi_device

`default_nettype wire

// ---- verification/idi_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Bus controller model: source, acceptor and management lines
// ****************************************************************
module idi_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] dio_n_i,
  input  wire logic       dav_n_i,
  input  wire logic       nrfd_n_i,
  input  wire logic       ndac_n_i,
  input  wire logic       eoi_n_i,
  output var  logic [7:0] dio_n_o,
  output var  logic       dav_n_o,
  output var  logic       nrfd_n_o,
  output var  logic       ndac_n_o,
  output var  logic       eoi_n_o,
  output var  logic       atn_n_o,
  output var  logic       ifc_n_o,
  output var  logic       ren_n_o
);
  // Everything released: the terminations pull the lines high
  initial begin
    dio_n_o  = 8'hff;
    dav_n_o  = 1'h1;
    nrfd_n_o = 1'h1;
    ndac_n_o = 1'h1;
    eoi_n_o  = 1'h1;
    atn_n_o  = 1'h1;
    ifc_n_o  = 1'h1;
    ren_n_o  = 1'h1;
  end

  // Management lines, active high arguments, changed after a falling edge
  task automatic lines(input logic atn, input logic eoi, input logic ren, input logic ifc);
    @(negedge clk_i);
    atn_n_o = ~atn;
    eoi_n_o = ~eoi;
    ren_n_o = ~ren;
    ifc_n_o = ~ifc;
  endtask

  // Source one byte; attention stays as asked until the next byte
  task automatic send(input logic atn, input logic [7:0] b, input logic eoi, output logic ok);
    int n;
    @(negedge clk_i);
    nrfd_n_o = 1'h1;
    ndac_n_o = 1'h1;
    atn_n_o  = ~atn;
    dio_n_o  = ~b;
    eoi_n_o  = ~eoi;
    n = 0;
    // Data settles a cycle before valid, then wait for all acceptors ready
    do begin
      @(negedge clk_i);
      n++;
    end while (nrfd_n_i !== 1'h1 && n < 64);
    dav_n_o = 1'h0;
    // Byte and valid stand until accepted; bounded so a hang is seen
    while (ndac_n_i !== 1'h1 && n < 128) begin
      @(negedge clk_i);
      n++;
    end
    ok = (n < 128);
    @(negedge clk_i);
    dav_n_o = 1'h1;
    dio_n_o = 8'hff;
    eoi_n_o = 1'h1;
  endtask

  // Accept one byte from the device as talker
  task automatic recv(output logic [7:0] b, output logic eoi, output logic ok);
    int n;
    @(negedge clk_i);
    ndac_n_o = 1'h0;
    nrfd_n_o = 1'h1;
    n = 0;
    while (dav_n_i !== 1'h0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    b   = ~dio_n_i;
    eoi = ~eoi_n_i;
    // Not ready for more, byte accepted
    @(negedge clk_i);
    nrfd_n_o = 1'h0;
    ndac_n_o = 1'h1;
    while (dav_n_i !== 1'h1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    ok = (n < 200);
    @(negedge clk_i);
    ndac_n_o = 1'h0;
  endtask
endmodule // idi_ctrl_model

`default_nettype wire

// ---- verification/ieee488_device_interface_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Device interface bench
// ****************************************************************
module ieee488_device_interface_bench;
  logic       ref_clk, rst, local_key, tx_eoi, tx_valid, rqs, ren_on, talk_only;
  logic [4:0] my_addr;                         // Primary address
  logic [7:0] tx_data, status, rx_data, d_dio_n, m_dio_n, last_rx;
  logic       d_dio_oe, d_dav_n, d_dav_oe, d_nrfd_n, d_nrfd_oe, d_ndac_n, d_ndac_oe;
  logic       d_eoi_n, d_eoi_oe, d_srq_n, d_srq_oe, tx_ready, rx_valid, rx_eoi, last_eoi;
  logic       dev_clear, trigger, remote, lockout, listen, talk, spoll;
  logic       m_dav_n, m_nrfd_n, m_ndac_n, m_eoi_n, atn_n, ifc_n, ren_n;
  int         fails, n_compared, n_clr, n_trg, n_rx, cyc;
  // Wired-AND of both parties: any low wins, released lines pull high
  wire [7:0]  dio_bus  = (d_dio_oe ? d_dio_n : 8'hff) & m_dio_n;
  wire        dav_bus  = ~(d_dav_oe & ~d_dav_n) & m_dav_n;
  wire        nrfd_bus = ~(d_nrfd_oe & ~d_nrfd_n) & m_nrfd_n;
  wire        ndac_bus = ~(d_ndac_oe & ~d_ndac_n) & m_ndac_n;
  wire        eoi_bus  = ~(d_eoi_oe & ~d_eoi_n) & m_eoi_n;
  wire        srq_bus  = ~(d_srq_oe & ~d_srq_n);
  wire [7:0]  mla      = {3'h1, my_addr};     // Own listen address
  wire [7:0]  mta      = {3'h2, my_addr};     // Own talk address

  idi_device u_idi_device (.ref_clk_i(ref_clk), .rst_i(rst), .dio_n_i(dio_bus),
    .dio_n_o(d_dio_n), .dio_oe_o(d_dio_oe), .dav_n_i(dav_bus), .dav_n_o(d_dav_n),
    .dav_oe_o(d_dav_oe), .nrfd_n_i(nrfd_bus), .nrfd_n_o(d_nrfd_n), .nrfd_oe_o(d_nrfd_oe),
    .ndac_n_i(ndac_bus), .ndac_n_o(d_ndac_n), .ndac_oe_o(d_ndac_oe), .eoi_n_i(eoi_bus),
    .eoi_n_o(d_eoi_n), .eoi_oe_o(d_eoi_oe), .srq_n_i(srq_bus), .srq_n_o(d_srq_n),
    .srq_oe_o(d_srq_oe), .atn_n_i(atn_n), .ifc_n_i(ifc_n), .ren_n_i(ren_n),
    .my_addr_i(my_addr), .talk_only_i(talk_only), .local_key_i(local_key), .tx_data_i(tx_data),
    .tx_eoi_i(tx_eoi), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_eoi_o(rx_eoi), .rx_valid_o(rx_valid), .status_i(status), .rqs_i(rqs),
    .dev_clear_o(dev_clear), .trigger_o(trigger), .remote_o(remote), .lockout_o(lockout),
    .listen_o(listen), .talk_o(talk), .spoll_o(spoll));

  idi_ctrl_model u_idi_ctrl_model (.clk_i(ref_clk), .dio_n_i(dio_bus), .dav_n_i(dav_bus),
    .nrfd_n_i(nrfd_bus), .ndac_n_i(ndac_bus), .eoi_n_i(eoi_bus), .dio_n_o(m_dio_n),
    .dav_n_o(m_dav_n), .nrfd_n_o(m_nrfd_n), .ndac_n_o(m_ndac_n), .eoi_n_o(m_eoi_n),
    .atn_n_o(atn_n), .ifc_n_o(ifc_n), .ren_n_o(ren_n));

  // 200 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Pulse counters and cycle ceiling; counting avoids missing one-cycle pulses
  always @(posedge ref_clk) begin
    cyc++;
    if (dev_clear === 1'h1) n_clr++;
    if (trigger === 1'h1) n_trg++;
    if (rx_valid === 1'h1) begin
      n_rx++;
      last_rx  = rx_data;
      last_eoi = rx_eoi;
    end
    if (cyc == 30000) begin
      fails++;
      report_and_stop;
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // One controller byte, handshake completion judged
  task automatic put(input logic atn, input logic [7:0] b, input logic eoi);
    logic ok;
    u_idi_ctrl_model.send(atn, b, eoi, ok);
    chk_bit("handshake", 1'h1, ok);
  endtask

  // Let synchroniser and pulses settle
  task automatic idle;
    repeat (8) @(negedge ref_clk);
  endtask

  // Offer a byte to the talker, held until taken
  task automatic push(input logic [7:0] b, input logic e);
    int n;
    @(negedge ref_clk);
    tx_data  = b;
    tx_eoi   = e;
    tx_valid = 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (tx_ready !== 1'h1 && n < 100);
    @(negedge ref_clk);
    tx_valid = 1'h0;
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_addr;
    int c, t;
    c = n_clr;
    t = n_trg;
    put(1'h1, 8'h3f, 1'h0);
    put(1'h1, 8'h04, 1'h0);
    idle;
    chk_bit("clear unaddressed", 1'h1, n_clr == c);
    put(1'h1, 8'h3f, 1'h0);
    put(1'h1, mla, 1'h0);
    put(1'h1, 8'h04, 1'h0);
    idle;
    chk_bit("listen", 1'h1, listen);
    chk_bit("selective clear", 1'h1, n_clr == c + 1);
    put(1'h1, 8'h08, 1'h0);
    put(1'h1, 8'h14, 1'h0);
    idle;
    chk_bit("trigger", 1'h1, n_trg == t + 1);
    chk_bit("device clear", 1'h1, n_clr == c + 2);
    put(1'h1, 8'h3f, 1'h0);
    put(1'h1, 8'h08, 1'h0);
    idle;
    chk_bit("trigger unaddressed", 1'h1, n_trg == t + 1);
    chk_bit("unlisten", 1'h0, listen);
    $display("test addressed commands done");
  endtask

  task automatic t_data;
    logic [7:0] msg [4];
    int r, c;
    msg = '{8'h2a, 8'h52, 8'h53, 8'h54};
    put(1'h1, mla, 1'h0);
    r = n_rx;
    c = n_clr;
    for (int i = 0; i < 4; i++) begin
      put(1'h0, msg[i], i == 3);
      idle;
      chk_byte("data byte", msg[i], last_rx);
    end
    chk_bit("end flag", 1'h1, last_eoi);
    put(1'h0, 8'h04, 1'h0);
    idle;
    chk_bit("byte count", 1'h1, n_rx == r + 5);
    chk_bit("data as command", 1'h1, n_clr == c);
    put(1'h1, 8'h3f, 1'h0);
    put(1'h0, 8'h41, 1'h0);
    idle;
    chk_bit("data unaddressed", 1'h1, n_rx == r + 5);
    chk_bit("acceptor drive", 1'h0, d_ndac_oe | d_nrfd_oe);
    $display("test listener data done");
  endtask

  task automatic t_talk;
    logic [7:0] b;
    logic       e, ok;
    chk_bit("ready unaddressed", 1'h0, tx_ready);
    put(1'h1, mla, 1'h0);
    put(1'h1, mta, 1'h0);
    u_idi_ctrl_model.lines(1'h0, 1'h0, ren_on, 1'h0);
    idle;
    chk_bit("listen after talk", 1'h0, listen);
    chk_bit("talk", 1'h1, talk);
    fork
      push(8'hc3, 1'h1);
      u_idi_ctrl_model.recv(b, e, ok);
    join
    chk_byte("talker byte", 8'hc3, b);
    chk_bit("talker end", 1'h1, e & ok);
    put(1'h1, 8'h61, 1'h0);
    idle;
    chk_bit("secondary", 1'h1, talk);
    put(1'h1, mla, 1'h0);
    idle;
    chk_bit("talk after listen", 1'h0, talk);
    put(1'h1, 8'h3f, 1'h0);
    // Talk-only sends with no talk address; the strap is tied off again after the byte
    u_idi_ctrl_model.lines(1'h0, 1'h0, ren_on, 1'h0);
    @(negedge ref_clk);
    talk_only = 1'h1;
    fork
      push(8'h5a, 1'h0);
      u_idi_ctrl_model.recv(b, e, ok);
    join
    chk_byte("talk-only byte", 8'h5a, b & {8{ok}});
    @(negedge ref_clk);
    talk_only = 1'h0;
    $display("test talker done");
  endtask

  task automatic t_spoll;
    logic [7:0] b;
    logic       e, ok;
    @(negedge ref_clk);
    rqs = 1'h1;
    @(negedge ref_clk);
    rqs = 1'h0;
    idle;
    chk_bit("request line", 1'h0, srq_bus);
    put(1'h1, 8'h18, 1'h0);
    put(1'h1, mta, 1'h0);
    u_idi_ctrl_model.lines(1'h0, 1'h0, ren_on, 1'h0);
    u_idi_ctrl_model.recv(b, e, ok);
    chk_byte("status byte", status | 8'h40, b & {8{ok}});
    idle;
    chk_bit("request serviced", 1'h1, srq_bus);
    // Attention with end asks for a parallel poll; nothing may answer
    u_idi_ctrl_model.lines(1'h1, 1'h1, ren_on, 1'h0);
    repeat (8) begin
      @(negedge ref_clk);
      chk_bit("poll reply", 1'h0, d_dio_oe);
    end
    put(1'h1, 8'h19, 1'h0);
    put(1'h1, 8'h5f, 1'h0);
    idle;
    chk_bit("poll disabled", 1'h0, spoll);
    chk_bit("untalk", 1'h0, talk);
    $display("test serial poll done");
  endtask

  task automatic t_remote;
    ren_on = 1'h1;
    u_idi_ctrl_model.lines(1'h0, 1'h0, 1'h1, 1'h0);
    put(1'h1, mla, 1'h0);
    put(1'h1, 8'h11, 1'h0);
    idle;
    chk_bit("remote", 1'h1, remote);
    chk_bit("lockout", 1'h1, lockout);
    @(negedge ref_clk);
    local_key = 1'h1;
    @(negedge ref_clk);
    local_key = 1'h0;
    idle;
    chk_bit("key locked out", 1'h1, remote);
    put(1'h1, 8'h01, 1'h0);
    idle;
    chk_bit("go to local", 1'h0, remote);
    ren_on = 1'h0;
    u_idi_ctrl_model.lines(1'h0, 1'h0, 1'h0, 1'h0);
    idle;
    chk_bit("lockout cleared", 1'h0, lockout);
    $display("test remote done");
  endtask

  task automatic t_ifc;
    put(1'h1, mla, 1'h0);
    u_idi_ctrl_model.lines(1'h0, 1'h0, 1'h0, 1'h1);
    idle;
    chk_bit("listen cleared", 1'h0, listen);
    u_idi_ctrl_model.lines(1'h0, 1'h0, 1'h0, 1'h0);
    put(1'h1, mta, 1'h0);
    u_idi_ctrl_model.lines(1'h1, 1'h0, 1'h0, 1'h1);
    idle;
    chk_bit("talk cleared", 1'h0, talk);
    u_idi_ctrl_model.lines(1'h0, 1'h0, 1'h0, 1'h0);
    $display("test interface clear done");
  endtask

  // Main sequence
  initial begin
    rst       = 1'h1;
    my_addr   = 5'h10;
    local_key = 1'h0;
    tx_eoi    = 1'h0;
    tx_valid  = 1'h0;
    tx_data   = 8'h00;
    rqs       = 1'h0;
    ren_on    = 1'h0;
    talk_only = 1'h0;
    status    = 8'h05;
    repeat (4) @(negedge ref_clk);
    rst = 1'h0;
    t_addr;
    t_data;
    t_talk;
    t_spoll;
    t_remote;
    t_ifc;
    report_and_stop;
  end
endmodule // ieee488_device_interface_bench

`default_nettype wire
